// File: hw/cserr_counter.sv
// Saturating 16-bit clear-on-read error counter.
// Assumes err and clr are single-cycle, same-clock strobes.
`timescale 1ns/1ps
`default_nettype none
module cserr_counter #(
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Counter carrier
   cserr_cnt_if.counter cnt
);
   typedef struct packed {
      logic [15:0] count;
   } cserr_cnt_state_t;
   cserr_cnt_state_t state_r;
   cserr_cnt_state_t state_nxt;
   ////////////////////////////////////////////////////////////////////
   // Count logic; an error in the read cycle is kept so none is lost
   always_comb
   begin
      state_nxt = state_r;
      if (cnt.clr)
      begin
         state_nxt.count = cnt.err ? 16'h0001 : cserr_pkg::CLR_VALUE;
      end
      else if (cnt.err && state_r.count != 16'hffff)
      begin
         state_nxt.count = state_r.count + 16'h0001;
      end
   end
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r.count <= RESET_VAL;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end
   assign cnt.value = state_r.count;
endmodule : cserr_counter
`default_nettype wire

// File: hw/cserr_if.sv
// Carrier between the register group and its counter slice.
// Assumes one clock domain shared by both modules.
`timescale 1ns/1ps
`default_nettype none
interface cserr_cnt_if;
   logic err;
   logic clr;
   logic [15:0] value;
   modport owner (output err, output clr, input value);
   modport counter (input err, input clr, output value);
endinterface : cserr_cnt_if
`default_nettype wire

// File: hw/cserr_pkg.sv
// Constants of the channel status and error counter register group.
// Assumes a 16-bit register read port driven by a management front end.
package cserr_pkg;
   // Register offsets
   localparam logic [15:0] ADDR_HS_ERR = 16'h0010;
   localparam logic [15:0] ADDR_LS0_ERR = 16'h0011;
   localparam logic [15:0] ADDR_LS1_ERR = 16'h0012;
   localparam logic [15:0] ADDR_FLAGS = 16'h000f;
   // Reset and clear values
   localparam logic [15:0] RST_HS_ERR = 16'h0000;
   localparam logic [15:0] RST_LS_ERR = 16'hfffd;
   localparam logic [15:0] CLR_VALUE = 16'h0000;
   // Flag bit positions
   localparam int B_LS_ALIGN = 14;
   localparam int B_HIGHSIDE_SIGNAL_LOST = 13;
   localparam int B_HS_AZ = 12;
   localparam int B_HS_AGC = 11;
   localparam int B_HS_SYNC = 10;
   localparam int B_HS_BADCW = 8;
   localparam int B_TX_UNF = 7;
   localparam int B_TX_OVF = 6;
   localparam int B_RX_UNF = 5;
   localparam int B_RX_OVF = 4;
   localparam int B_LS_PLL = 1;
   localparam int B_HS_PLL = 0;
   // Latching-low bits, then latching-high bits; bits in neither are reserved
   localparam logic [15:0] LL_MASK = 16'h5c02;
   localparam logic [15:0] LH_MASK = 16'h21f1;
endpackage : cserr_pkg

// File: hw/cserr_regs.sv
// Channel status flags and error counters with a 16-bit read port.
// Assumes condition inputs come from other clock domains (synchronised
// here), error strobes come from same-clock decoders, and the read port
// is driven by a same-clock management front end.
// Limitations: a level must hold for at least three clocks to be seen
// for certain; event strobes must be clock-aligned pulses, each high
// cycle counting once; counters stop at all-ones instead of wrapping.
`timescale 1ns/1ps
`default_nettype none
module cserr_regs #(
   parameter int SYNC_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register read port
   input wire logic rd_en_i,
   input wire logic [15:0] rd_addr_i,
   output logic [15:0] rd_data_o,
   output logic rd_valid_o,
   // Live conditions, asynchronous levels
   input wire logic lowside_lanes_aligned_i,
   input wire logic highside_signal_lost_i,
   input wire logic highside_autozero_complete_i,
   input wire logic highside_gain_loop_locked_i,
   input wire logic highside_sync_achieved_i,
   input wire logic lowside_synth_locked_i,
   input wire logic highside_synth_locked_i,
   // Same-clock event strobes
   input wire logic highside_bad_codeword_i,
   input wire logic tx_fifo_underflow_i,
   input wire logic tx_fifo_overflow_i,
   input wire logic rx_fifo_underflow_i,
   input wire logic rx_fifo_overflow_i,
   input wire logic lowside_lane0_bad_codeword_i,
   input wire logic lowside_lane1_bad_codeword_i,
   // Test pattern checker error strobes and mode
   input wire logic highside_pattern_error_i,
   input wire logic lowside_lane0_pattern_error_i,
   input wire logic lowside_lane1_pattern_error_i,
   input wire logic highside_verify_en_i,
   input wire logic lowside_verify_en_i,
   input wire logic pseudo_random_test_pin_i,
   // Side effect on the outside 8-bit field
   output logic highside_aux_field_clr_o
);
   typedef struct packed {
      logic [2:0][SYNC_W-1:0] sync;
      logic [SYNC_W-1:0] agreed;
      logic [15:0] latched;
      logic [15:0] rdata;
      logic rvalid;
      logic aux_clr;
   } cserr_state_t;
   cserr_state_t state_r;
   cserr_state_t state_nxt;
   logic [SYNC_W-1:0] live_sync;
   logic [SYNC_W-1:0] settled;
   logic [15:0] live_flags;
   logic [15:0] event_flags;
   logic hs_test;
   logic rd_flags;
   logic rd_hs;
   logic rd_ls0;
   logic rd_ls1;
   cserr_cnt_if hs_cnt();
   cserr_cnt_if ls0_cnt();
   cserr_cnt_if ls1_cnt();

   // Address match helper used by every decode
   function automatic logic addr_hit(input logic [15:0] a,
                                     input logic [15:0] b);
      addr_hit = (a == b);
   endfunction : addr_hit

   // Settle step of the synchroniser: a bit takes the value of stages
   // two and three once they agree and keeps its last agreed value while
   // they differ, so a pin caught mid-change cannot flicker through
   function automatic logic [SYNC_W-1:0] settle(
      input logic [SYNC_W-1:0] stage2,
      input logic [SYNC_W-1:0] stage3,
      input logic [SYNC_W-1:0] held);
      logic [SYNC_W-1:0] agree;
      agree = ~(stage2 ^ stage3);
      settle = (stage3 & agree) | (held & ~agree);
   endfunction : settle

   // Error source of one counter: pattern checker errors while its
   // verification mode is on, decoder bad code words otherwise
   function automatic logic pick_err(input logic test_mode,
                                     input logic pattern_err,
                                     input logic bad_word);
      pick_err = test_mode ? pattern_err : bad_word;
   endfunction : pick_err

   // One step of the flags image outside a read: latch-high bits collect
   // every event; latch-low bits keep a one only while the live level
   // stays high, so a drop is held until the next read sees it
   function automatic logic [15:0] latch_step(input logic [15:0] held,
                                              input logic [15:0] live);
      latch_step = ((held | live) & cserr_pkg::LH_MASK)
                 | (held & live & cserr_pkg::LL_MASK);
   endfunction : latch_step

   // Image returned by a flags read: the held value with any latch-high
   // event of the read cycle merged in, so an event that lands in the
   // read cycle is reported now and also kept for the next read; the
   // reserved bits always read as zero
   function automatic logic [15:0] read_image(input logic [15:0] held,
                                              input logic [15:0] live);
      read_image = (held | (live & cserr_pkg::LH_MASK))
                 & (cserr_pkg::LH_MASK | cserr_pkg::LL_MASK);
   endfunction : read_image

   ////////////////////////////////////////////////////////////////////
   // Input synchroniser, three stages; a change counts once stages two
   // and three agree, so stage one feeds only stage two.
   // Word order, lowest bit first: high-side PLL, low-side PLL, sync,
   // gain loop, auto-zero, loss of signal, lane alignment; the unused
   // upper bits of a wider word stay zero
   assign live_sync = SYNC_W'({lowside_lanes_aligned_i,
      highside_signal_lost_i, highside_autozero_complete_i,
      highside_gain_loop_locked_i, highside_sync_achieved_i,
      lowside_synth_locked_i, highside_synth_locked_i});

   // Settled levels; the held copy sits in the state so that a bit whose
   // stages disagree keeps its last agreed value in both directions
   assign settled = settle(state_r.sync[1], state_r.sync[2],
                           state_r.agreed);

   // Live condition image from the settled levels and the event strobes
   always_comb
   begin
      live_flags = 16'h0000;
      live_flags[cserr_pkg::B_LS_ALIGN] = settled[6];
      live_flags[cserr_pkg::B_HIGHSIDE_SIGNAL_LOST] = settled[5];
      live_flags[cserr_pkg::B_HS_AZ] = settled[4];
      live_flags[cserr_pkg::B_HS_AGC] = settled[3];
      live_flags[cserr_pkg::B_HS_SYNC] = settled[2];
      live_flags[cserr_pkg::B_LS_PLL] = settled[1];
      live_flags[cserr_pkg::B_HS_PLL] = settled[0];
      live_flags[cserr_pkg::B_HS_BADCW] = highside_bad_codeword_i;
      live_flags[cserr_pkg::B_TX_UNF] = tx_fifo_underflow_i;
      live_flags[cserr_pkg::B_TX_OVF] = tx_fifo_overflow_i;
      live_flags[cserr_pkg::B_RX_UNF] = rx_fifo_underflow_i;
      live_flags[cserr_pkg::B_RX_OVF] = rx_fifo_overflow_i;
   end
   // Event strobes are same-clock and enter unsynchronised; the level
   // bits above have already passed the settle step, so a single-stage
   // glitch can latch neither a false drop nor a false rise
   assign event_flags = live_flags;

   ////////////////////////////////////////////////////////////////////
   // Read decode; offsets are compared in full, so aliases of the
   // counters and of the flags register read as unmapped
   assign rd_flags = rd_en_i & addr_hit(rd_addr_i, cserr_pkg::ADDR_FLAGS);
   assign rd_hs = rd_en_i & addr_hit(rd_addr_i, cserr_pkg::ADDR_HS_ERR);
   assign rd_ls0 = rd_en_i & addr_hit(rd_addr_i, cserr_pkg::ADDR_LS0_ERR);
   assign rd_ls1 = rd_en_i & addr_hit(rd_addr_i, cserr_pkg::ADDR_LS1_ERR);

   ////////////////////////////////////////////////////////////////////
   // Counter sources
   // The test pin overrides the high-side mode bit, so high-side pattern
   // errors are counted while either of the two is active
   // pin forces pattern counting
   assign hs_test = highside_verify_en_i | pseudo_random_test_pin_i;
   assign hs_cnt.err = pick_err(hs_test, highside_pattern_error_i,
                                highside_bad_codeword_i);
   assign ls0_cnt.err = pick_err(lowside_verify_en_i,
                                 lowside_lane0_pattern_error_i,
                                 lowside_lane0_bad_codeword_i);
   assign ls1_cnt.err = pick_err(lowside_verify_en_i,
                                 lowside_lane1_pattern_error_i,
                                 lowside_lane1_bad_codeword_i);
   assign hs_cnt.clr = rd_hs;
   assign ls0_cnt.clr = rd_ls0;
   assign ls1_cnt.clr = rd_ls1;

   // Counters stop at all-ones rather than wrap, so a long error burst
   // never reads back as a small count
   // high-side counter resets to zero
   cserr_counter #(.RESET_VAL(cserr_pkg::RST_HS_ERR)) u_hs_cnt (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .cnt(hs_cnt.counter)
   );
   cserr_counter #(.RESET_VAL(cserr_pkg::RST_LS_ERR)) u_ls0_cnt (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .cnt(ls0_cnt.counter)
   );
   cserr_counter #(.RESET_VAL(cserr_pkg::RST_LS_ERR)) u_ls1_cnt (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .cnt(ls1_cnt.counter)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state: synchroniser shift, latching flags, read data
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.sync[0] = live_sync;
      state_nxt.sync[1] = state_r.sync[0];
      state_nxt.sync[2] = state_r.sync[1];
      // Held copy of the settled levels for the next settle step
      state_nxt.agreed = settled;
      // read returns latched image then reloads live value
      // an event in the read cycle sets again, so set wins
      if (rd_flags)
      begin
         state_nxt.latched = event_flags;
      end
      else
      begin
         state_nxt.latched = latch_step(state_r.latched, event_flags);
      end
      state_nxt.rvalid = rd_en_i;
      // clear outside field on high-side counter read
      state_nxt.aux_clr = rd_hs;
      // Data reads zero outside the answer cycle; an unmapped offset
      // still answers, with zero data, so a station never waits
      state_nxt.rdata = 16'h0000;
      if (rd_flags)
      begin
         // Read shows held value merged with current event for no loss
         state_nxt.rdata = read_image(state_r.latched, event_flags);
      end
      else if (rd_hs)
      begin
         state_nxt.rdata = hs_cnt.value;
      end
      else if (rd_ls0)
      begin
         state_nxt.rdata = ls0_cnt.value;
      end
      else if (rd_ls1)
      begin
         state_nxt.rdata = ls1_cnt.value;
      end
   end

   // State register; reset clears the synchroniser as well, so the first
   // settled levels after reset come from fresh samples only
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Outputs, straight from the state register so the read port has no
   // combinational path from any input
   assign rd_data_o = state_r.rdata;
   assign rd_valid_o = state_r.rvalid;
   assign highside_aux_field_clr_o = state_r.aux_clr;
endmodule : cserr_regs
`default_nettype wire

// File: verif/cserr_mgmt_model.sv
// Management station model issuing reads to the register group.
// Assumes requests launch on falling edges of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module cserr_mgmt_model (
   // Clock and answer
   input wire logic clk_i,
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i,
   // Request
   output logic rd_en_o,
   output logic [15:0] rd_addr_o
);
   initial
   begin
      rd_en_o = 1'b0;
      rd_addr_o = 16'h0000;
   end
   // Back-to-back reads; the answer of the last one is returned
   task automatic rd(input logic [15:0] a, input int n,
                     output logic [15:0] d);
      repeat (n)
      begin
         @(negedge clk_i);
         rd_en_o = 1'b1;
         rd_addr_o = a;
      end
      @(negedge clk_i);
      rd_en_o = 1'b0;
      // Released address is scrambled so no stale value helps
      rd_addr_o = ~a;
      d = rd_valid_i ? rd_data_i : 16'hxxxx;
   endtask : rd
endmodule : cserr_mgmt_model
`default_nettype wire

// File: verif/cserr_regs_sva.sv
// Checker of the register group read port and its side effects.
// Assumes one clock domain and a bind onto cserr_regs.
`timescale 1ns/1ps
`default_nettype none
module cserr_regs_chk (
   // Clock, reset and read port
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic rd_en_i,
   input wire logic [15:0] rd_addr_i,
   input wire logic [15:0] rd_data_o,
   input wire logic rd_valid_o,
   // Strobes and side effect
   input wire logic highside_bad_codeword_i,
   input wire logic highside_pattern_error_i,
   input wire logic tx_fifo_underflow_i,
   input wire logic rx_fifo_overflow_i,
   input wire logic lowside_lane0_bad_codeword_i,
   input wire logic lowside_lane1_bad_codeword_i,
   input wire logic lowside_lane0_pattern_error_i,
   input wire logic lowside_lane1_pattern_error_i,
   input wire logic highside_aux_field_clr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   ////////////////////////////////////////////////////////////////////////
   // aux clear
   property p_aux;
      rd_en_i && rd_addr_i == 16'h0010 |=> highside_aux_field_clr_o;
   endproperty
   a_aux: assert property (p_aux) else $error("no aux clear");
   // aux clear only after a high-side counter read
   property p_aux_only;
      !(rd_en_i && rd_addr_i == 16'h0010) |=> !highside_aux_field_clr_o;
   endproperty
   a_aux_only: assert property (p_aux_only) else $error("aux stray");
   property p_idle;
      !rd_en_i |=> !rd_valid_o && rd_data_o == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("port not quiet");
   // second read zero; errors in the first read cycle would count
   property p_hs_cor;
      rd_en_i && rd_addr_i == 16'h0010 && !highside_bad_codeword_i &&
      !highside_pattern_error_i ##1 rd_en_i && rd_addr_i == 16'h0010
         |=> rd_data_o == 16'h0000;
   endproperty
   a_hs_cor: assert property (p_hs_cor) else $error("hs not cleared");
   property p_l0_cor;
      rd_en_i && rd_addr_i == 16'h0011 && !lowside_lane0_bad_codeword_i
         && !lowside_lane0_pattern_error_i
         ##1 rd_en_i && rd_addr_i == 16'h0011 |=> rd_data_o == 16'h0000;
   endproperty
   a_l0_cor: assert property (p_l0_cor) else $error("l0 not cleared");
   property p_l1_cor;
      rd_en_i && rd_addr_i == 16'h0012 && !lowside_lane1_bad_codeword_i
         && !lowside_lane1_pattern_error_i
         ##1 rd_en_i && rd_addr_i == 16'h0012 |=> rd_data_o == 16'h0000;
   endproperty
   a_l1_cor: assert property (p_l1_cor) else $error("l1 not cleared");
   property p_bad;
      highside_bad_codeword_i
      ##1 !(rd_en_i && rd_addr_i == cserr_pkg::ADDR_FLAGS)
      ##1 rd_en_i && rd_addr_i == cserr_pkg::ADDR_FLAGS |=> rd_data_o[8];
   endproperty
   a_bad: assert property (p_bad) else $error("bad word lost");
   property p_txu;
      rd_valid_o && $past(rd_addr_i) == cserr_pkg::ADDR_FLAGS &&
      !($past(rd_en_i, 2) &&
        $past(rd_addr_i, 2) == cserr_pkg::ADDR_FLAGS) &&
      $past(tx_fifo_underflow_i, 3) |-> rd_data_o[7];
   endproperty
   a_txu: assert property (p_txu) else $error("tx underflow lost");
   property p_rxo;
      rd_valid_o && $past(rd_addr_i) == cserr_pkg::ADDR_FLAGS &&
      !($past(rd_en_i, 2) &&
        $past(rd_addr_i, 2) == cserr_pkg::ADDR_FLAGS) &&
      $past(rx_fifo_overflow_i, 3) |-> rd_data_o[4];
   endproperty
   a_rxo: assert property (p_rxo) else $error("rx overflow lost");
endmodule : cserr_regs_chk
bind cserr_regs cserr_regs_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
   .rd_valid_o(rd_valid_o),
   .highside_bad_codeword_i(highside_bad_codeword_i),
   .highside_pattern_error_i(highside_pattern_error_i),
   .tx_fifo_underflow_i(tx_fifo_underflow_i),
   .rx_fifo_overflow_i(rx_fifo_overflow_i),
   .lowside_lane0_bad_codeword_i(lowside_lane0_bad_codeword_i),
   .lowside_lane1_bad_codeword_i(lowside_lane1_bad_codeword_i),
   .lowside_lane0_pattern_error_i(lowside_lane0_pattern_error_i),
   .lowside_lane1_pattern_error_i(lowside_lane1_pattern_error_i),
   .highside_aux_field_clr_o(highside_aux_field_clr_o));
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the status flags and error counters.
// Assumes the management model is the only reader of the port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] FL = cserr_pkg::ADDR_FLAGS;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic rd_en, rd_valid, hv = 1'b0, lvf = 1'b0, pin = 1'b0;
   logic [15:0] rd_addr, rd_data;
   logic [9:0] ev = 10'h000;
   logic [6:0] lv = 7'h00;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   // Clock
   always #5 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////
   cserr_mgmt_model mdl (.clk_i(clk_i), .rd_valid_i(rd_valid),
      .rd_data_i(rd_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
   cserr_regs uut (.clk_i(clk_i), .nrst_i(nrst_i), .rd_en_i(rd_en),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .lowside_lanes_aligned_i(lv[0]), .highside_signal_lost_i(lv[1]),
      .highside_autozero_complete_i(lv[2]),
      .highside_gain_loop_locked_i(lv[3]),
      .highside_sync_achieved_i(lv[4]), .lowside_synth_locked_i(lv[5]),
      .highside_synth_locked_i(lv[6]), .highside_bad_codeword_i(ev[0]),
      .tx_fifo_underflow_i(ev[1]), .tx_fifo_overflow_i(ev[2]),
      .rx_fifo_underflow_i(ev[3]), .rx_fifo_overflow_i(ev[4]),
      .lowside_lane0_bad_codeword_i(ev[5]),
      .lowside_lane1_bad_codeword_i(ev[6]),
      .highside_pattern_error_i(ev[7]),
      .lowside_lane0_pattern_error_i(ev[8]),
      .lowside_lane1_pattern_error_i(ev[9]),
      .highside_verify_en_i(hv), .lowside_verify_en_i(lvf),
      .pseudo_random_test_pin_i(pin), .highside_aux_field_clr_o());
   ////////////////////////////////////////////////////////////////////////
   // Read and compare
   task automatic chk(input logic [15:0] a, input int n,
                      input logic [15:0] e);
      logic [15:0] r;
      mdl.rd(a, n, r);
      checks++;
      if (r !== e)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, r, e);
      end
   endtask : chk
   // One-cycle strobes with a gap, so each counts once
   task automatic pulse(input logic [9:0] v, input int n);
      repeat (n)
      begin
         @(negedge clk_i);
         ev = v;
         @(negedge clk_i);
         ev = 10'h000;
      end
   endtask : pulse
   task automatic print_verdict();
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // Hang guard, far above the roughly 130 cycles needed
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // Main sequence
   initial
   begin
      repeat (20) @(negedge clk_i);
      nrst_i = 1'b1;
      for (int i = 0; i < 3; i++)
         chk(16'h0010 + 16'(i), 1, i ? 16'hfffd : 16'h0000);
      for (int i = 0; i < 3; i++)
         chk(16'h0010 + 16'(i), 2, 16'h0000);
      chk(16'h0020, 1, 16'h0000);
      lv = 7'h7d;
      repeat (10) @(negedge clk_i);
      chk(FL, 1, 16'h0001);
      chk(FL, 1, 16'h5c03);
      lv = 7'h02;
      repeat (8) @(negedge clk_i);
      lv = 7'h7d;
      repeat (8) @(negedge clk_i);
      chk(FL, 1, 16'h2001);
      chk(FL, 1, 16'h5c03);
      pulse(10'h01f, 1);
      chk(FL, 1, 16'h5df3);
      chk(FL, 1, 16'h5c03);
      chk(16'h0010, 1, 16'h0001);
      pulse(10'h001, 3);
      pulse(10'h080, 1);
      chk(16'h0010, 1, 16'h0003);
      hv = 1'b1;
      pulse(10'h080, 2);
      pulse(10'h001, 1);
      chk(16'h0010, 1, 16'h0002);
      hv = 1'b0;
      pin = 1'b1;
      pulse(10'h080, 1);
      pulse(10'h001, 2);
      chk(16'h0010, 1, 16'h0001);
      pin = 1'b0;
      pulse(10'h060, 2);
      pulse(10'h300, 1);
      chk(16'h0011, 1, 16'h0002);
      chk(16'h0012, 1, 16'h0002);
      lvf = 1'b1;
      pulse(10'h300, 3);
      pulse(10'h060, 1);
      chk(16'h0011, 1, 16'h0003);
      chk(16'h0012, 1, 16'h0003);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
